// ===== shared/servo_regs_pkg.sv
// constants, offsets and carriers for the dedicated data register bank
package servo_regs_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CL_TORQUE   = 8'hce;
    localparam logic [7:0] IDX_OL_TORQUE   = 8'hcf;
    localparam logic [7:0] IDX_ERR_LIMITS  = 8'hd0;
    localparam logic [7:0] IDX_DIR_IO      = 8'hd1;
    localparam logic [7:0] IDX_KILL_CAUSE  = 8'hd3;
    localparam logic [7:0] IDX_ANALOG_12   = 8'hd4;
    localparam logic [7:0] IDX_ANALOG_34   = 8'hd5;
    localparam logic [7:0] IDX_SUPPLY_TEMP = 8'hd6;
    localparam logic [7:0] IDX_HC_VOLT     = 8'hd7;
    localparam logic [7:0] IDX_MAX_VOLT    = 8'hd8;
    localparam logic [7:0] IDX_HC_MAXTEMP  = 8'hd9;
    localparam logic [7:0] IDX_COMM_ADDR   = 8'hdb;
    localparam logic [7:0] IDX_ENC_ANGLE   = 8'hea;
    localparam logic [7:0] IDX_STATUS_TWO  = 8'hec;
    localparam logic [7:0] IDX_EXT_IO      = 8'hee;
    localparam logic [7:0] IDX_MOTOR_TEMP  = 8'hf1;
    localparam logic [7:0] IDX_CMD_ERR     = 8'hf3;
    localparam logic [7:0] IDX_UP_TIMER    = 8'hf4;
    localparam logic [7:0] IDX_DOWN_TIMER  = 8'hf5;
    localparam logic [7:0] IDX_CAN_NET     = 8'hf6;
    localparam logic [7:0] IDX_CAN_STATUS  = 8'hf7;
    localparam logic [7:0] IDX_T2_ACC      = 8'hf8;
    localparam logic [7:0] IDX_ERR_LOADADR = 8'hf9;
    localparam logic [7:0] IDX_T2_LOADADR  = 8'hfa;
    localparam logic [7:0] IDX_T2_BUFWIN   = 8'hfb;
    // internal status two bit positions
    localparam int STS_IO_LO         = 12;
    localparam int STS_XIO_POWER     = 9;
    localparam int STS_ENC_ANALOG    = 8;
    localparam int STS_HW_OVERTEMP   = 7;
    localparam int STS_DRIVE_ENABLE  = 6;
    localparam int STS_DRV_OVERTEMP  = 5;
    localparam int STS_MOTOR_TEMP    = 4;
    localparam int STS_FACTORY_DIS   = 3;
    localparam int STS_ENC_REPHASE   = 2;
    localparam int STS_DOWN_ZERO     = 1;
    // can error status: bits 8..3 write-one-to-clear, 2..0 read only
    localparam int CES_W1C_LO        = 3;
    localparam int CES_W1C_HI        = 8;
    localparam int CAN_STATUS_LO     = 16;
    // trajectory state codes stored with a command error
    localparam logic [15:0] TRAJ_INVALID_REG = 16'h0081;
    localparam logic [15:0] TRAJ_PROHIBITED  = 16'h0084;
    localparam logic [15:0] TRAJ_OUT_RANGE   = 16'h0088;
    localparam logic [15:0] CMD_ERR_MAX      = 16'h000c;
    // millisecond tick timing
    localparam int CLK_HZ      = 100_000_000;
    localparam int TICK_MS     = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  idx;
        logic [31:0] wdata;
    } reg_req_t;

    // live analog readings
    typedef struct packed {
        logic [15:0] ain1;
        logic [15:0] ain2;
        logic [15:0] ain3;
        logic [15:0] ain4;
        logic [15:0] supply;
        logic [15:0] cpu_temp;
        logic [15:0] hc_volt;
        logic [15:0] hc_temp;
        logic [15:0] motor_temp;
    } analog_t;

    // command error capture request
    typedef struct packed {
        logic        valid;
        logic [15:0] cause;
        logic [15:0] traj;
    } cmd_err_t;
endpackage

// ===== verilog/servo_dedicated_data_registers.sv
// dedicated data register bank 206..251 of the servo controller
`timescale 1ns/1ps
module servo_dedicated_data_registers
    import servo_regs_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
)(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // register port from the link and threads
    input  wire reg_req_t    req,
    output logic [31:0]      rdata,
    output logic             rvalid,
    // kill capture
    input  wire logic        kill_event,
    input  wire logic [15:0] kill_conditions,
    input  wire logic [15:0] kill_states,
    // command error capture
    input  wire cmd_err_t    cmd_err,
    // live data
    input  wire analog_t     analog,
    input  wire logic [15:0] static_words [0:5],
    input  wire logic [15:0] comm_addr,
    input  wire logic [15:0] enc_cpr,
    input  wire logic [15:0] enc_position,
    input  wire logic        enc_index_pulse,
    input  wire logic [15:0] dir_sense,
    input  wire logic [15:0] io_status_word,
    input  wire logic [15:0] eeprom_load_address,
    input  wire logic [31:0] t2_buffer_window,
    // asynchronous pin levels
    input  wire logic [3:0]  io_lines_hi,
    input  wire logic [15:0] ext_inputs,
    input  wire logic [4:0]  live_faults,
    input  wire logic [2:0]  latch_events,
    // can controller mirrors
    input  wire logic [15:0] can_error_register,
    input  wire logic [7:0]  can_network_state,
    input  wire logic [5:0]  can_err_events,
    input  wire logic [2:0]  can_err_levels,
    input  wire logic [5:0]  can_global_status,
    // thread two accumulator write from its own thread
    input  wire logic        t2_acc_we,
    input  wire logic [31:0] t2_acc_wdata,
    // outputs to motion logic and pins
    output logic [31:0]      cl_torque,
    output logic [31:0]      ol_torque,
    output logic [31:0]      error_limits,
    output logic [15:0]      ext_outputs,
    output logic             motor_overtemp,
    output logic [31:0]      t2_accumulator
);
    // register storage
    logic [31:0] kill_cause;       // conditions:states
    logic [31:0] motor_temp_max;   // only high half used
    logic [31:0] cmd_err_capture;  // cause:trajectory
    logic [31:0] up_timer;         // free running ms
    logic [31:0] down_timer;       // stops at zero
    logic        down_zero;        // set once down timer hits zero
    logic [2:0]  status_latched;   // power, analog, rephase
    logic        index_seen;       // modulo angle valid
    logic [5:0]  can_err_sticky;   // write-one-clear flags
    logic [16:0] tick_cnt;         // ms prescaler
    logic        ms_tick;          // one cycle per millisecond
    logic [31:0] ext_io_out;       // low half only
    // two-stage synchronisers for pin inputs
    logic [37:0] sync_a;
    logic [37:0] sync_b;
    logic [37:0] pins_raw;
    logic [15:0] status_two;
    logic [31:0] next_rdata;

    assign pins_raw = {io_lines_hi, ext_inputs, live_faults, latch_events,
                       can_err_events, can_err_levels, 1'b0};

    // pins cross into the clock domain before any use
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
        end
    end

    // register writes of host settings, any time even during motion
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            cl_torque    <= RESET_WORD;
            ol_torque    <= RESET_WORD;
            error_limits <= RESET_WORD;
            ext_io_out   <= RESET_WORD;
            motor_temp_max <= RESET_WORD;
        end
        else if (req.wr)
        begin
            unique case (req.idx)
                IDX_CL_TORQUE:  cl_torque    <= req.wdata;
                IDX_OL_TORQUE:  ol_torque    <= req.wdata;
                IDX_ERR_LIMITS: error_limits <= req.wdata;
                IDX_EXT_IO:     ext_io_out   <= {16'h0000, req.wdata[15:0]};
                // measured half is live, only the limit is kept
                IDX_MOTOR_TEMP: motor_temp_max <= {req.wdata[31:16], 16'h0000};
                default:        ;
            endcase
        end
    end
    assign ext_outputs = ext_io_out[15:0];

    // over-temperature compare, a zero maximum disables it
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            motor_overtemp <= 1'b0;
        else
            motor_overtemp <= (motor_temp_max[31:16] != 16'h0000) &&
                              (analog.motor_temp > motor_temp_max[31:16]);
    end

    // kill capture; a hardware capture wins over a software write
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            kill_cause <= RESET_WORD;
        else if (kill_event)
            kill_cause <= {kill_conditions, kill_states};
        else if (req.wr && req.idx == IDX_KILL_CAUSE)
            kill_cause <= req.wdata;
    end

    // command error capture; only causes 1..12 are taken
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            cmd_err_capture <= RESET_WORD;
        else if (cmd_err.valid && cmd_err.cause != 16'h0000 &&
                 cmd_err.cause <= CMD_ERR_MAX)
            cmd_err_capture <= {cmd_err.cause, cmd_err.traj};
        else if (req.wr && req.idx == IDX_CMD_ERR)
            cmd_err_capture <= req.wdata;
    end

    // millisecond prescaler
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            tick_cnt <= '0;
            ms_tick  <= 1'b0;
        end
        else if (tick_cnt == 17'(TICK_COUNT - 1))
        begin
            tick_cnt <= '0;
            ms_tick  <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 17'd1;
            ms_tick  <= 1'b0;
        end
    end

    // up timer wraps naturally; a write takes priority over the tick
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            up_timer <= RESET_WORD;
        else if (req.wr && req.idx == IDX_UP_TIMER)
            up_timer <= req.wdata;
        else if (ms_tick)
            up_timer <= up_timer + 32'd1;
    end

    // down timer stops at zero and raises the status flag
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            down_timer <= RESET_WORD;
            down_zero  <= 1'b0;
        end
        else if (req.wr && req.idx == IDX_DOWN_TIMER)
        begin
            down_timer <= req.wdata;
            down_zero  <= (req.wdata == 32'h0000_0000);
        end
        else if (ms_tick && down_timer != 32'h0000_0000)
        begin
            down_timer <= down_timer - 32'd1;
            down_zero  <= (down_timer == 32'd1);
        end
    end

    // latched status flags; cleared only by reset
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            status_latched <= 3'b000;
        else
            status_latched <= status_latched | sync_b[12:10];
    end

    // modulo angle becomes valid after first index
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            index_seen <= 1'b0;
        else if (enc_index_pulse)
            index_seen <= 1'b1;
    end

    // can error flags: set wins over a write-one clear
    generate
        for (genvar i = 0; i < 6; i++)
        begin : g_can_err
            always_ff @(posedge clk_sys)
            begin
                if (!rstn)
                    can_err_sticky[i] <= 1'b0;
                else if (sync_b[i + 4])
                    can_err_sticky[i] <= 1'b1;
                else if (req.wr && req.idx == IDX_CAN_STATUS &&
                         req.wdata[CAN_STATUS_LO + CES_W1C_LO + i])
                    can_err_sticky[i] <= 1'b0;
            end
        end
    endgenerate

    // thread two accumulator shared by its thread and the links
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            t2_accumulator <= RESET_WORD;
        else if (t2_acc_we)
            t2_accumulator <= t2_acc_wdata;
        else if (req.wr && req.idx == IDX_T2_ACC)
            t2_accumulator <= req.wdata;
    end

    // status word two assembly
    always_comb
    begin
        status_two = 16'h0000;
        status_two[15:STS_IO_LO]       = sync_b[37:34];
        status_two[STS_XIO_POWER]      = status_latched[2];
        status_two[STS_ENC_ANALOG]     = status_latched[1];
        status_two[STS_HW_OVERTEMP:STS_FACTORY_DIS] = sync_b[17:13];
        status_two[STS_ENC_REPHASE]    = status_latched[0];
        status_two[STS_DOWN_ZERO]      = down_zero;
    end

    // read mux; unmapped and reserved indices read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (req.idx)
            IDX_CL_TORQUE:   next_rdata = cl_torque;
            IDX_OL_TORQUE:   next_rdata = ol_torque;
            IDX_ERR_LIMITS:  next_rdata = error_limits;
            IDX_DIR_IO:      next_rdata = {dir_sense, io_status_word};
            IDX_KILL_CAUSE:  next_rdata = kill_cause;
            IDX_ANALOG_12:   next_rdata = {analog.ain1, analog.ain2};
            IDX_ANALOG_34:   next_rdata = {analog.ain3, analog.ain4};
            IDX_SUPPLY_TEMP: next_rdata = {analog.supply, analog.cpu_temp};
            IDX_HC_VOLT:     next_rdata = {analog.hc_volt, analog.hc_temp};
            IDX_MAX_VOLT:    next_rdata = {static_words[0], static_words[1]};
            IDX_HC_MAXTEMP:  next_rdata = {static_words[2], static_words[3]};
            IDX_COMM_ADDR:   next_rdata = {comm_addr, 16'h0000};
            IDX_ENC_ANGLE:   next_rdata = {enc_cpr,
                                 index_seen ? enc_position : 16'h0000};
            IDX_STATUS_TWO:  next_rdata = {status_two, 16'h0000};
            IDX_EXT_IO:      next_rdata = {sync_b[33:18], ext_io_out[15:0]};
            IDX_MOTOR_TEMP:  next_rdata = {motor_temp_max[31:16], analog.motor_temp};
            IDX_CMD_ERR:     next_rdata = cmd_err_capture;
            IDX_UP_TIMER:    next_rdata = up_timer;
            IDX_DOWN_TIMER:  next_rdata = down_timer;
            IDX_CAN_NET:     next_rdata = {can_error_register,
                                           8'h00, can_network_state};
            IDX_CAN_STATUS:  next_rdata = {7'h00, can_err_sticky, sync_b[3:1],
                                           10'h000, can_global_status[5:3],
                                           1'b0, can_global_status[1:0]};
            IDX_T2_ACC:      next_rdata = t2_accumulator;
            IDX_ERR_LOADADR: next_rdata = {eeprom_load_address, 16'h0000};
            IDX_T2_LOADADR:  next_rdata = {static_words[4], 16'h0000};
            IDX_T2_BUFWIN:   next_rdata = t2_buffer_window;
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    // read data registered one cycle after request; reads have no side effect
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            rdata  <= RESET_WORD;
            rvalid <= 1'b0;
        end
        else
        begin
            rdata  <= req.rd ? next_rdata : rdata;
            rvalid <= req.rd;
        end
    end

    // checks
    a_kill_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
        kill_event |=> kill_cause == {$past(kill_conditions), $past(kill_states)})
        else $error("kill cause not captured");
    a_torque_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        req.wr && req.idx == IDX_CL_TORQUE |=> cl_torque == $past(req.wdata))
        else $error("torque write lost");
    a_limit_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        req.wr && req.idx == IDX_ERR_LIMITS |=> error_limits == $past(req.wdata))
        else $error("error limit write lost");
    a_up_tick: assert property (@(posedge clk_sys) disable iff (!rstn)
        ms_tick && !(req.wr && req.idx == IDX_UP_TIMER) |=>
        up_timer == $past(up_timer) + 32'd1)
        else $error("up timer missed tick");
    // a timer idle at zero keeps its flag as it was; after reset it never reached zero
    a_down_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
        down_timer == 32'h0 && !(req.wr && req.idx == IDX_DOWN_TIMER) |=>
        down_timer == 32'h0 && down_zero == $past(down_zero))
        else $error("down timer moved past zero");
    a_down_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
        ms_tick && down_timer == 32'h1 && !(req.wr && req.idx == IDX_DOWN_TIMER) |=>
        down_timer == 32'h0 && down_zero)
        else $error("down timer zero flag not raised");
    // flag standing with no clear of its bit in this cycle
    sequence s_err_set;
        can_err_sticky[0] &&
        !(req.wr && req.idx == IDX_CAN_STATUS && req.wdata[CAN_STATUS_LO + CES_W1C_LO]);
    endsequence
    a_can_w1c_ro: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_err_set |=> can_err_sticky[0])
        else $error("can error flag dropped without clear");
    a_latch_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        status_latched[0] |=> status_latched[0])
        else $error("latched status bit fell");
    a_angle_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
        req.rd && req.idx == IDX_ENC_ANGLE && !index_seen |=> rdata[15:0] == 16'h0)
        else $error("angle shown before index");
    a_overtemp_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        motor_temp_max[31:16] == 16'h0 |=> !motor_overtemp)
        else $error("overtemp with check disabled");
endmodule

// ===== test/host_model.sv
// host model: register reads and writes over the serial or can link
`timescale 1ns/1ps
module host_model
    import servo_regs_pkg::*;
(
    // clock
    input  wire logic        clk_sys,
    // register port
    output reg_req_t         req,
    input  wire logic [31:0] rdata,
    input  wire logic        rvalid
);
    // idle port from time zero, strobes low
    initial req = '0;

    // one write, held over exactly one rising edge
    // flag clearing is a plain write of ones
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        @(negedge clk_sys);
        req = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
        @(negedge clk_sys);
        req = '0;
    endtask

    // one read; answer stands one cycle, so look at it then
    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        @(negedge clk_sys);
        req = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 32'h0};
        @(negedge clk_sys);
        req = '0;
        // a missing answer shows as unknown and fails the compare
        d = (rvalid === 1'b1) ? rdata : 32'hxxxx_xxxx;
    endtask
endmodule

// ===== test/tb_top.sv
// self-checking bench for the dedicated data register bank
`timescale 1ns/1ps
module tb_top
    import servo_regs_pkg::*;
;
    // clock, reset and counters
    logic        clk_sys = 1'b0, rstn = 1'b0;
    int          mismatches = 0, samples_checked = 0, cycles = 0;
    // register port
    reg_req_t    req;
    logic [31:0] rdata, v;
    logic        rvalid;
    // design inputs
    logic        kill_event, enc_index_pulse, t2_acc_we;
    logic [15:0] kill_conditions, kill_states, comm_addr, enc_cpr, enc_position;
    logic [15:0] dir_sense, io_status_word, eeprom_load_address, ext_inputs;
    logic [15:0] can_error_register, static_words [0:5];
    logic [31:0] t2_buffer_window, t2_acc_wdata;
    logic [3:0]  io_lines_hi;
    logic [4:0]  live_faults;
    logic [2:0]  latch_events, can_err_levels;
    logic [7:0]  can_network_state;
    logic [5:0]  can_err_events, can_global_status;
    cmd_err_t    cmd_err;
    analog_t     analog;
    // design outputs
    logic [31:0] cl_torque, ol_torque, error_limits, t2_accumulator;
    logic [15:0] ext_outputs;
    logic        motor_overtemp;
    // captured command error table: cause and trajectory code
    logic [15:0] causes [0:2] = '{16'h0001, 16'h0004, 16'h0008};
    logic [15:0] trajs [0:2] = '{TRAJ_INVALID_REG, TRAJ_PROHIBITED, TRAJ_OUT_RANGE};

    // 100 mhz clock
    always #5 clk_sys = ~clk_sys;

    // short tick keeps the millisecond timers fast in simulation
    servo_dedicated_data_registers #(.TICK_COUNT(10)) u_servo_dedicated_data_registers (
        .clk_sys(clk_sys), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid),
        .kill_event(kill_event), .kill_conditions(kill_conditions),
        .kill_states(kill_states), .cmd_err(cmd_err), .analog(analog),
        .static_words(static_words), .comm_addr(comm_addr), .enc_cpr(enc_cpr),
        .enc_position(enc_position), .enc_index_pulse(enc_index_pulse),
        .dir_sense(dir_sense), .io_status_word(io_status_word),
        .eeprom_load_address(eeprom_load_address), .t2_buffer_window(t2_buffer_window),
        .io_lines_hi(io_lines_hi), .ext_inputs(ext_inputs), .live_faults(live_faults),
        .latch_events(latch_events), .can_error_register(can_error_register),
        .can_network_state(can_network_state), .can_err_events(can_err_events),
        .can_err_levels(can_err_levels), .can_global_status(can_global_status),
        .t2_acc_we(t2_acc_we), .t2_acc_wdata(t2_acc_wdata), .cl_torque(cl_torque),
        .ol_torque(ol_torque), .error_limits(error_limits), .ext_outputs(ext_outputs),
        .motor_overtemp(motor_overtemp), .t2_accumulator(t2_accumulator));

    // far-side host
    host_model u_host_model (.clk_sys(clk_sys), .req(req), .rdata(rdata), .rvalid(rvalid));

    // single compare point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read one register and compare
    task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
        u_host_model.rd(idx, v);
        check(v, exp);
    endtask

    // wait whole cycles, landing on a falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // closing report
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard: whole run needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    initial
    begin
        // every input defined at time zero
        {kill_event, enc_index_pulse, t2_acc_we, t2_acc_wdata} = '0;
        {kill_conditions, kill_states, cmd_err, latch_events, can_err_events} = '0;
        analog = {16'h0101, 16'h0202, 16'h0303, 16'h0404, 16'h0505, 16'h0606,
                  16'h0707, 16'h0808, 16'h0700};
        static_words = '{16'h0011, 16'h0022, 16'h0033, 16'h0044, 16'h0055, 16'h0066};
        {comm_addr, enc_cpr, enc_position} = {16'h0a05, 16'h1000, 16'h0123};
        {dir_sense, io_status_word, eeprom_load_address} = {16'h0001, 16'h5a5a, 16'h0200};
        {t2_buffer_window, ext_inputs, io_lines_hi} = {32'h0400_0100, 16'h8421, 4'ha};
        {live_faults, can_err_levels, can_global_status} = {5'b10101, 3'b101, 6'h3f};
        {can_error_register, can_network_state} = {16'h0081, 8'h05};
        cyc(10);
        rstn = 1'b1;
        check(cl_torque | ol_torque | error_limits | t2_accumulator, 32'h0);
        // successive torque and limit writes, one idle cycle apart
        u_host_model.wr(IDX_CL_TORQUE, 32'h0011_0022);
        u_host_model.wr(IDX_OL_TORQUE, 32'h0033_0044);
        u_host_model.wr(IDX_ERR_LIMITS, 32'h0055_0066);
        check(cl_torque, 32'h0011_0022);
        check(ol_torque, 32'h0033_0044);
        check(error_limits, 32'h0055_0066);
        rc(IDX_ERR_LIMITS, 32'h0055_0066);
        rc(IDX_DIR_IO, 32'h0001_5a5a);
        // kill capture, then software zeroes it
        {kill_conditions, kill_states, kill_event} = {16'h00c3, 16'h0042, 1'b1};
        cyc(1);
        kill_event = 1'b0;
        rc(IDX_KILL_CAUSE, 32'h00c3_0042);
        u_host_model.wr(IDX_KILL_CAUSE, 32'h0);
        rc(IDX_KILL_CAUSE, 32'h0);
        // analog readings; a write to a read-only place is ignored
        u_host_model.wr(IDX_ANALOG_12, 32'h0);
        rc(IDX_ANALOG_12, 32'h0101_0202);
        rc(IDX_ANALOG_34, 32'h0303_0404);
        rc(IDX_SUPPLY_TEMP, 32'h0505_0606);
        rc(IDX_COMM_ADDR, 32'h0a05_0000);
        u_host_model.wr(8'hda, 32'hffff_ffff);
        rc(8'hda, 32'h0);
        // angle reads zero until the index is seen
        rc(IDX_ENC_ANGLE, 32'h1000_0000);
        enc_index_pulse = 1'b1;
        cyc(1);
        enc_index_pulse = 1'b0;
        cyc(2);
        rc(IDX_ENC_ANGLE, 32'h1000_0123);
        // extended io
        u_host_model.wr(IDX_EXT_IO, 32'hffff_00f0);
        check({16'h0, ext_outputs}, 32'h0000_00f0);
        rc(IDX_EXT_IO, 32'h8421_00f0);
        // motor temperature limit; zero disables the check
        u_host_model.wr(IDX_MOTOR_TEMP, 32'h0640_0000);
        cyc(3);
        check({31'h0, motor_overtemp}, 32'h1);
        rc(IDX_MOTOR_TEMP, 32'h0640_0700);
        u_host_model.wr(IDX_MOTOR_TEMP, 32'h0);
        cyc(3);
        check({31'h0, motor_overtemp}, 32'h0);
        // every stored trajectory code, then an out-of-range cause
        for (int i = 0; i < 4; i++)
        begin
            cmd_err = '{valid: 1'b1, cause: (i < 3) ? causes[i] : 16'h000d,
                        traj: trajs[(i < 3) ? i : 0]};
            cyc(1);
            cmd_err = '0;
            rc(IDX_CMD_ERR, {causes[(i < 3) ? i : 2], trajs[(i < 3) ? i : 2]});
        end
        // up timer wraps: 2 or 3 ticks after the write
        u_host_model.wr(IDX_UP_TIMER, 32'hffff_fffe);
        cyc(24);
        u_host_model.rd(IDX_UP_TIMER, v);
        check({31'h0, v <= 32'h1}, 32'h1);
        // down timer stops at zero and raises its flag
        u_host_model.wr(IDX_DOWN_TIMER, 32'h2);
        cyc(40);
        rc(IDX_DOWN_TIMER, 32'h0);
        // status two: latched, live and mirrored bits
        latch_events = 3'b111;
        cyc(1);
        latch_events = 3'b000;
        cyc(4);
        rc(IDX_STATUS_TWO, 32'ha3ae_0000);
        live_faults = 5'b00000;
        cyc(4);
        rc(IDX_STATUS_TWO, 32'ha306_0000);
        rc(IDX_CAN_NET, 32'h0081_0005);
        // can flags: set on event, cleared only by writing ones
        can_err_events = 6'h3f;
        cyc(1);
        can_err_events = 6'h00;
        cyc(4);
        rc(IDX_CAN_STATUS, 32'h01fd_003b);
        u_host_model.wr(IDX_CAN_STATUS, 32'h007f_0000);
        rc(IDX_CAN_STATUS, 32'h0185_003b);
        // accumulator from the link, then from its own thread
        u_host_model.wr(IDX_T2_ACC, 32'h1234_5678);
        check(t2_accumulator, 32'h1234_5678);
        {t2_acc_we, t2_acc_wdata} = {1'b1, 32'hcafe_0001};
        cyc(1);
        t2_acc_we = 1'b0;
        rc(IDX_T2_ACC, 32'hcafe_0001);
        // a second reset clears the latched bits and the zero flag
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(2);
        rc(IDX_STATUS_TWO, 32'ha000_0000);
        print_verdict();
    end
endmodule
